// ### src/flash_spc_pkg.sv
// Contract
// - erase acts on a whole row only
// - two setup cycles after start, software places nops; the controller forces these nops itself on CORE_FORCE_NOP_O
// - core halted for self-timed erase, clocks keep running
// - resume at third instruction after the start
// - programming never erases anything by itself
// - at most thirty-two words per row write
// - upper ten address bits row, low five latch
// - one programming operation stays inside one row
// - latches return to blank after write or erase
// - unloaded latches stay blank and program blank
// - latch load copies fourteen-bit data word
// - latch-only-load set: load latch, no programming
// - latch-only-load clear: load latch, program row
// - broken unlock starts neither load nor programming
// - start bits set-only, cleared by hardware
// - reset during write or erase sets error flag
// - key register write-only, reads as zero
package flash_spc_pkg;
  // register offsets on the byte-wide register port
  localparam int unsigned REG_ADDR_W          = 3;
  localparam logic [2:0]  FLASH_CONTROL_OFS   = 3'h0;
  localparam logic [2:0]  UNLOCK_KEY_OFS      = 3'h1;
  localparam logic [2:0]  FLASH_ADDR_LOW_OFS  = 3'h2;
  localparam logic [2:0]  FLASH_ADDR_HIGH_OFS = 3'h3;
  localparam logic [2:0]  FLASH_DATA_LOW_OFS  = 3'h4;
  localparam logic [2:0]  FLASH_DATA_HIGH_OFS = 3'h5;
  // control register bit positions
  localparam int unsigned CTRL_READ_BIT       = 0;
  localparam int unsigned CTRL_START_BIT      = 1;
  localparam int unsigned CTRL_ENABLE_BIT     = 2;
  localparam int unsigned CTRL_ERROR_BIT      = 3;
  localparam int unsigned CTRL_ERASE_BIT      = 4;
  localparam int unsigned CTRL_LOAD_ONLY_BIT  = 5;
  localparam int unsigned CTRL_CFG_SEL_BIT    = 6;
  localparam int unsigned CTRL_PAD_BIT        = 7;
  // unlock keys and blank word
  localparam logic [7:0]  KEY_FIRST           = 8'h55;
  localparam logic [7:0]  KEY_SECOND          = 8'haa;
  localparam logic [13:0] BLANK_WORD          = 14'h3fff;
  // geometry
  localparam int unsigned DATA_W              = 14;
  localparam int unsigned ADDR_W              = 15;
  localparam int unsigned ROW_W               = 10;
  localparam int unsigned LATCH_IDX_W         = 5;
  localparam int unsigned LATCH_COUNT         = 32;
  // timing
  localparam int unsigned SETUP_CYCLES        = 2;
  localparam int unsigned CLK_FREQ_KHZ        = 20000;
  localparam int unsigned OP_TIME_US          = 2000;
  localparam int unsigned OP_CYCLES           = OP_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int unsigned COUNT_W             = 24;
  // reset values
  localparam logic [7:0]  RDATA_RESET         = 8'h00;
  localparam logic        PAD_READ_ONE        = 1'b1;
endpackage

// ### src/flash_reset_err_tracker.sv
`timescale 1ns/10ps
// remembers an unfinished write or erase across a device reset
module flash_reset_err_tracker (
  input  wire logic clk_i,       // core clock
  input  wire logic por_n_i,     // power-on reset, low active
  input  wire logic sys_rst_n_i, // device reset pin, low active
  input  wire logic start_i,     // write or erase begins
  input  wire logic done_i,      // write or erase ends normally
  input  wire logic clear_i,     // software writes zero to the flag
  output logic      err_o        // error flag
);
  typedef struct packed {
    logic sync1;    // first stage, read only by sync2
    logic sync2;    // device reset seen in this domain
    logic pending;  // an operation is in flight
    logic err;      // sticky error flag
  } track_t;

  track_t s;       // registered state
  track_t next_s;  // next state

  // next state: pending is not in the device reset; seeing that reset moves it into the error flag
  always_comb begin
    next_s = s;
    next_s.sync1 = sys_rst_n_i;
    next_s.sync2 = s.sync1;
    if (start_i) begin
      next_s.pending = 1'b1;
    end else if (done_i) begin
      next_s.pending = 1'b0;
    end
    if (clear_i) begin
      next_s.err = 1'b0;
    end
    // a reset while pending sets the flag; set wins over clear
    if (!s.sync2 && s.pending) begin
      next_s.err     = 1'b1;
      next_s.pending = 1'b0;
    end
  end

  // state register, cleared only at power-on
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign err_o = s.err;
endmodule // flash_reset_err_tracker

// ### src/flash_self_program_ctrl.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// row erase and row programming sequencer with unlock-guarded write latches
module flash_self_program_ctrl #(
  parameter int unsigned OP_CYCLES = flash_spc_pkg::OP_CYCLES  // self-timed period
) (
  input  wire logic        CORE_CLK_I,        // 20 MHz core clock
  input  wire logic        RST_N_I,           // device reset, low active
  input  wire logic        POR_N_I,           // power-on reset, low active
  input  wire logic [2:0]  ADDR_I,            // register index
  input  wire logic [7:0]  WDATA_I,           // register write data
  input  wire logic        WR_I,              // register write strobe
  input  wire logic        RD_I,              // register read strobe
  output logic      [7:0]  RDATA_O,           // read data, cycle after strobe
  output logic             FLASH_ERASE_O,     // one-cycle row erase command
  output logic             FLASH_WRITE_O,     // one-cycle word program command
  output logic      [14:0] FLASH_ADDR_O,      // flash word address
  output logic      [13:0] FLASH_WDATA_O,     // flash word to program
  output logic             CORE_STALL_O,      // halts instruction execution
  output logic             CORE_FORCE_NOP_O   // core executes forced nops
);
  localparam int unsigned CW = flash_spc_pkg::COUNT_W;
  localparam int unsigned LN = flash_spc_pkg::LATCH_COUNT;
  localparam int unsigned DW = flash_spc_pkg::DATA_W;

  // refuse periods the counter cannot hold
  if (OP_CYCLES < 1 || OP_CYCLES >= (1 << CW)) begin : g_bad_op_cycles
    $error("OP_CYCLES out of range");
  end

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,    // waiting for an unlocked start
    ST_SETUP,   // forced-nop cycles after the start
    ST_PROG,    // stream latches into the row
    ST_WAIT     // self-timed erase or program period
  } state_t;

  // whole module state
  typedef struct packed {
    state_t                  state;       // sequencer state
    logic                    cfg_sel;     // config space select
    logic                    load_only;   // latch-only-load bit
    logic                    erase_sel;   // erase select, hardware cleared
    logic                    prog_en;     // program enable
    logic                    start;       // write-start bit
    logic [7:0]              addr_low;    // address low byte
    logic [6:0]              addr_high;   // address high bits
    logic [7:0]              data_low;    // data low byte
    logic [5:0]              data_high;   // data high bits
    logic [1:0]              key_step;    // unlock progress
    logic [CW-1:0]           count;       // cycle counter
    logic [4:0]              prog_idx;    // latch being programmed
    logic [9:0]              row;         // row captured at start
    logic                    op_load;     // running op is a latch load
    logic                    op_erase;    // running op is an erase
    logic [LN-1:0][DW-1:0]   latch;       // write latches
    logic [7:0]              rdata;       // read data register
    logic                    flash_erase; // erase pulse
    logic                    flash_write; // program pulse
    logic [14:0]             flash_addr;  // flash address out
    logic [13:0]             flash_wdata; // flash data out
    logic                    stall;       // core stall
    logic                    force_nop;   // forced nop window
  } ctrl_t;

  ctrl_t s;        // registered state
  ctrl_t next_s;   // next state
  logic  err;      // error flag from the tracker
  logic  op_start; // a write or erase begins this cycle
  logic  op_done;  // a write or erase ends this cycle
  logic  err_clr;  // software clears the error flag

  // true when a strobe addresses the given register
  function automatic logic hits(input logic strobe, input logic [2:0] addr,
                                input logic [2:0] ofs);
    hits = strobe && (addr == ofs);
  endfunction

  // next-state logic: register port, unlock tracking, sequencer
  always_comb begin
    logic        ctrl_wr;    // control register written
    logic        key_wr;     // key register written
    logic        go;         // unlocked, enabled start request
    logic [4:0]  slot;       // latch chosen by the low address
    next_s             = s;
    ctrl_wr            = hits(WR_I, ADDR_I, flash_spc_pkg::FLASH_CONTROL_OFS);
    key_wr             = hits(WR_I, ADDR_I, flash_spc_pkg::UNLOCK_KEY_OFS);
    slot               = s.addr_low[4:0];
    go                 = 1'b0;
    op_start           = 1'b0;
    op_done            = 1'b0;
    err_clr            = 1'b0;
    next_s.flash_erase = 1'b0;
    next_s.flash_write = 1'b0;
    next_s.rdata       = flash_spc_pkg::RDATA_RESET;

    // read data stand for exactly one cycle
    if (RD_I) begin
      case (ADDR_I)
        flash_spc_pkg::FLASH_CONTROL_OFS: begin
          next_s.rdata = {flash_spc_pkg::PAD_READ_ONE, s.cfg_sel, s.load_only,
                          s.erase_sel, err, s.prog_en, s.start, 1'b0};
        end
        flash_spc_pkg::UNLOCK_KEY_OFS: begin
          next_s.rdata = 8'h00;
        end
        flash_spc_pkg::FLASH_ADDR_LOW_OFS: begin
          next_s.rdata = s.addr_low;
        end
        flash_spc_pkg::FLASH_ADDR_HIGH_OFS: begin
          next_s.rdata = {flash_spc_pkg::PAD_READ_ONE, s.addr_high};
        end
        flash_spc_pkg::FLASH_DATA_LOW_OFS: begin
          next_s.rdata = s.data_low;
        end
        flash_spc_pkg::FLASH_DATA_HIGH_OFS: begin
          next_s.rdata = {2'b00, s.data_high};
        end
        default: begin
          next_s.rdata = 8'h00; // unmapped reads as zero
        end
      endcase
    end

    // unlock tracker: the keys must be back to back, then the start
    if (key_wr) begin
      if (WDATA_I == flash_spc_pkg::KEY_FIRST) begin
        next_s.key_step = 2'd1;
      end else if (WDATA_I == flash_spc_pkg::KEY_SECOND && s.key_step == 2'd1) begin
        next_s.key_step = 2'd2;
      end else begin
        next_s.key_step = 2'd0;
      end
    end else if (WR_I || RD_I) begin
      next_s.key_step = 2'd0;
    end

    // plain data and address registers
    if (hits(WR_I, ADDR_I, flash_spc_pkg::FLASH_ADDR_LOW_OFS)) begin
      next_s.addr_low = WDATA_I;
    end
    if (hits(WR_I, ADDR_I, flash_spc_pkg::FLASH_ADDR_HIGH_OFS)) begin
      next_s.addr_high = WDATA_I[6:0];
    end
    if (hits(WR_I, ADDR_I, flash_spc_pkg::FLASH_DATA_LOW_OFS)) begin
      next_s.data_low = WDATA_I;
    end
    if (hits(WR_I, ADDR_I, flash_spc_pkg::FLASH_DATA_HIGH_OFS)) begin
      next_s.data_high = WDATA_I[5:0];
    end

    // control register write; start is set-only, read start is not served
    if (ctrl_wr) begin
      next_s.cfg_sel   = WDATA_I[flash_spc_pkg::CTRL_CFG_SEL_BIT];
      next_s.load_only = WDATA_I[flash_spc_pkg::CTRL_LOAD_ONLY_BIT];
      next_s.erase_sel = WDATA_I[flash_spc_pkg::CTRL_ERASE_BIT];
      next_s.prog_en   = WDATA_I[flash_spc_pkg::CTRL_ENABLE_BIT];
      err_clr          = !WDATA_I[flash_spc_pkg::CTRL_ERROR_BIT];
      // the written enable and selects decide; config space is not served here
      go = WDATA_I[flash_spc_pkg::CTRL_START_BIT] && (s.key_step == 2'd2) &&
           WDATA_I[flash_spc_pkg::CTRL_ENABLE_BIT] &&
           !WDATA_I[flash_spc_pkg::CTRL_CFG_SEL_BIT] &&
           (s.state == ST_IDLE) && !s.start;
    end

    // sequencer
    case (s.state)
      ST_IDLE: begin
        if (go) begin
          next_s.start     = 1'b1;
          next_s.state     = ST_SETUP;
          next_s.count     = CW'(flash_spc_pkg::SETUP_CYCLES - 1);
          next_s.force_nop = 1'b1;
          next_s.row       = {s.addr_high, s.addr_low[7:5]};
          next_s.op_erase  = WDATA_I[flash_spc_pkg::CTRL_ERASE_BIT];
          next_s.op_load   = WDATA_I[flash_spc_pkg::CTRL_LOAD_ONLY_BIT] &&
                             !WDATA_I[flash_spc_pkg::CTRL_ERASE_BIT];
          // a row write or latch load first stores the addressed word
          if (!WDATA_I[flash_spc_pkg::CTRL_ERASE_BIT]) begin
            next_s.latch[slot] = {s.data_high, s.data_low};
          end
          // only real flash operations can be cut short by a reset
          op_start = !(WDATA_I[flash_spc_pkg::CTRL_LOAD_ONLY_BIT] &&
                       !WDATA_I[flash_spc_pkg::CTRL_ERASE_BIT]);
        end
      end
      ST_SETUP: begin
        if (s.count != '0) begin
          next_s.count = s.count - CW'(1);
        end else begin
          next_s.force_nop = 1'b0;
          if (s.op_load) begin
            // latch load ends with the forced nops, flash untouched
            next_s.start = 1'b0;
            next_s.state = ST_IDLE;
          end else if (s.op_erase) begin
            // any address in the row selects the whole row
            next_s.flash_erase = 1'b1;
            next_s.flash_addr  = {s.row, 5'h00};
            next_s.stall       = 1'b1;
            next_s.count       = CW'(OP_CYCLES - 1);
            next_s.state       = ST_WAIT;
          end else begin
            // no erase precedes programming
            next_s.stall    = 1'b1;
            next_s.prog_idx = 5'h00;
            next_s.state    = ST_PROG;
          end
        end
      end
      ST_PROG: begin
        // every latch goes out, blank ones program as blank
        next_s.flash_write = 1'b1;
        next_s.flash_addr  = {s.row, s.prog_idx};
        next_s.flash_wdata = s.latch[s.prog_idx];
        next_s.prog_idx    = s.prog_idx + 5'h01;
        if (s.prog_idx == 5'(LN - 1)) begin
          next_s.count = CW'(OP_CYCLES - 1);
          next_s.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (s.count != '0) begin
          next_s.count = s.count - CW'(1);
        end else begin
          // completion: release core, clear start and erase select, blank latches
          next_s.stall     = 1'b0;
          next_s.start     = 1'b0;
          next_s.erase_sel = 1'b0;
          next_s.latch     = {LN{flash_spc_pkg::BLANK_WORD}};
          next_s.state     = ST_IDLE;
          op_done          = 1'b1;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
  end

  // error flag survives device reset, cleared at power-on or by software writing zero
  flash_reset_err_tracker u_err (
    .clk_i       (CORE_CLK_I),
    .por_n_i     (POR_N_I),
    .sys_rst_n_i (RST_N_I),
    .start_i     (op_start),
    .done_i      (op_done),
    .clear_i     (err_clr),
    .err_o       (err)
  );

  // state register; latches come up blank
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s       <= '0;
      s.state <= ST_IDLE;
      s.latch <= {LN{flash_spc_pkg::BLANK_WORD}};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign RDATA_O          = s.rdata;
  assign FLASH_ERASE_O    = s.flash_erase;
  assign FLASH_WRITE_O    = s.flash_write;
  assign FLASH_ADDR_O     = s.flash_addr;
  assign FLASH_WDATA_O    = s.flash_wdata;
  assign CORE_STALL_O     = s.stall;
  assign CORE_FORCE_NOP_O = s.force_nop;
endmodule // flash_self_program_ctrl

// ### tb/flash_self_program_ctrl_properties.sv
`timescale 1ns/10ps
// watches only the sequencer ports; setup nops are counted from the start write, erase time from the start of the stall
module flash_spc_checker #(
  parameter int unsigned OP_CYCLES = 20  // self-timed period in cycles
) (
  input wire logic        CORE_CLK_I,       // core clock
  input wire logic        RST_N_I,          // device reset, low active
  input wire logic [2:0]  ADDR_I,           // register index
  input wire logic [7:0]  WDATA_I,          // register write data
  input wire logic        WR_I,             // write strobe
  input wire logic        RD_I,             // read strobe
  input wire logic [7:0]  RDATA_O,          // read data
  input wire logic        FLASH_ERASE_O,    // erase pulse
  input wire logic        FLASH_WRITE_O,    // program pulse
  input wire logic [14:0] FLASH_ADDR_O,     // flash address
  input wire logic        CORE_STALL_O,     // core halted
  input wire logic        CORE_FORCE_NOP_O  // forced nops
);
  logic [15:0] stall_cnt;  // cycles the core has been held so far
  logic        erase_op;   // the running stall belongs to an erase
  // helpers cleared by reset so a cut operation leaves nothing behind
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stall_cnt <= '0;
      erase_op  <= 1'b0;
    end else begin
      stall_cnt <= CORE_STALL_O ? stall_cnt + 16'h1 : '0;
      erase_op  <= FLASH_ERASE_O | (CORE_STALL_O & erase_op);
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // full unlock: both keys then an enabled start on consecutive accesses
  sequence s_key_start;
    WR_I && ADDR_I == 3'h1 && WDATA_I == 8'h55 ##1 WR_I && ADDR_I == 3'h1 && WDATA_I == 8'haa
    ##1 WR_I && ADDR_I == 3'h0 && WDATA_I[2:1] == 2'b11 && !WDATA_I[6]
    && !CORE_STALL_O && !CORE_FORCE_NOP_O;
  endsequence
  // two forced nop cycles, then released
  sequence s_setup;
    CORE_FORCE_NOP_O ##1 CORE_FORCE_NOP_O ##1 !CORE_FORCE_NOP_O;
  endsequence
  property p_setup; s_key_start |=> s_setup; endproperty
  a_setup: assert property (p_setup) else $error("setup nops missing");
  property p_nop_cause;
    $rose(CORE_FORCE_NOP_O) |-> $past(WR_I) && $past(ADDR_I) == 3'h0 && $past(WDATA_I[2:1]) == 2'b11;
  endproperty
  a_nop_cause: assert property (p_nop_cause) else $error("start without enable");
  property p_erase_slot;
    FLASH_ERASE_O |-> $past(CORE_FORCE_NOP_O) && CORE_STALL_O && FLASH_ADDR_O[4:0] == 5'h00;
  endproperty
  a_erase_slot: assert property (p_erase_slot) else $error("erase pulse misplaced");
  property p_write_stalled; FLASH_WRITE_O |-> CORE_STALL_O && !FLASH_ERASE_O; endproperty
  a_write_stalled: assert property (p_write_stalled) else $error("write while running");
  property p_burst_start; $rose(FLASH_WRITE_O) |-> FLASH_ADDR_O[4:0] == 5'h00; endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst not row aligned");
  property p_burst_step;
    FLASH_WRITE_O && FLASH_ADDR_O[4:0] != 5'h1f
      |=> FLASH_WRITE_O && FLASH_ADDR_O == $past(FLASH_ADDR_O) + 15'h1;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst step wrong");
  property p_burst_end; FLASH_WRITE_O && FLASH_ADDR_O[4:0] == 5'h1f |=> !FLASH_WRITE_O [*8];
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst longer than row");
  property p_erase_time; $fell(CORE_STALL_O) && erase_op |-> stall_cnt == 16'(OP_CYCLES);
  endproperty
  a_erase_time: assert property (p_erase_time) else $error("erase stall length wrong");
  property p_key_zero; RD_I && ADDR_I == 3'h1 |=> RDATA_O == 8'h00; endproperty
  a_key_zero: assert property (p_key_zero) else $error("key register readable");
endmodule // flash_spc_checker
bind flash_self_program_ctrl flash_spc_checker #(.OP_CYCLES(OP_CYCLES)) u_checker (
  .CORE_CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .FLASH_ERASE_O,
  .FLASH_WRITE_O, .FLASH_ADDR_O, .CORE_STALL_O, .CORE_FORCE_NOP_O);

// ### tb/flash_self_program_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
// software view of the sequencer: register calls plus watching flash pulses
module flash_self_program_ctrl_tb;
  logic        clk = 1'b0;    // 20 MHz core clock
  logic        rst_n = 1'b0;  // device reset
  logic        por_n = 1'b0;  // power-on reset
  logic [2:0]  addr = 3'h0;   // register index
  logic [7:0]  wdata = 8'h00; // write data
  logic        wr = 1'b0;     // write strobe
  logic        rd = 1'b0;     // read strobe
  logic [7:0]  rdata;         // read data
  logic        erase;         // erase pulse
  logic        fwrite;        // program pulse
  logic [14:0] faddr;         // flash address
  logic [13:0] fwdata;        // flash data
  logic        stall;         // core held
  logic        nop;           // forced nops
  logic [13:0] exp_lat [32];  // expected latch image
  int          failures = 0;
  int          comparisons = 0;
  int          pulses = 0;    // program pulses seen so far
  always #25 clk = ~clk;
  always @(posedge clk) if (fwrite === 1'b1) pulses++;
  flash_self_program_ctrl #(.OP_CYCLES(20)) u_dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .POR_N_I(por_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FLASH_ERASE_O(erase), .FLASH_WRITE_O(fwrite),
    .FLASH_ADDR_O(faddr), .FLASH_WDATA_O(fwdata), .CORE_STALL_O(stall),
    .CORE_FORCE_NOP_O(nop));
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // strobe stays up so consecutive writes land back to back
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    rd    <= 1'b0;
    addr  <= a;
    wdata <= d;
  endtask
  task automatic idle();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    wr   <= 1'b0;
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask
  task automatic unlock(input logic [7:0] ctrl);
    wr_reg(3'h1, flash_spc_pkg::KEY_FIRST);
    wr_reg(3'h1, flash_spc_pkg::KEY_SECOND);
    wr_reg(3'h0, ctrl);
    idle();
  endtask
  // nothing may start: the nop level must stay low
  task automatic quiet(input string n);
    repeat (4) begin @(posedge clk); #1; `CHK(n, 1'b0, nop) end
  endtask
  // bounded wait until the sequencer lets the core run again
  task automatic wait_idle();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (stall === 1'b0 && nop === 1'b0) return;
    end
    failures++;
    tally_and_finish();
  endtask
  // one row write: 32 pulses checked against the latch image
  task automatic row_burst(input logic [14:0] base);
    int n;
    n = 0;
    for (int i = 0; i < 120; i++) begin
      @(posedge clk);
      #1;
      if (fwrite === 1'b1) begin
        `CHK("program address", base + 15'(n), faddr)
        `CHK("program data", exp_lat[n[4:0]], fwdata)
        n++;
      end
    end
    `CHK("program count", 32, n)
    wait_idle();
    foreach (exp_lat[i]) exp_lat[i] = flash_spc_pkg::BLANK_WORD;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    foreach (exp_lat[i]) exp_lat[i] = flash_spc_pkg::BLANK_WORD;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rd_chk(3'h0, 8'h80, "control reset");
    rd_chk(3'h3, 8'h80, "address high reset");
    rd_chk(3'h6, 8'h00, "unmapped");
    wr_reg(3'h5, 8'hff);
    rd_chk(3'h5, 8'h3f, "data high");
    wr_reg(3'h1, 8'h55);
    rd_chk(3'h1, 8'h00, "key readback");
    $display("test registers done");
    // erase target inside row 0x2b, bad sequences first
    wr_reg(3'h2, 8'h7b);
    wr_reg(3'h3, 8'h05);
    wr_reg(3'h0, 8'h16);
    idle();
    quiet("start without keys");
    // a wrong second key must cancel, so the following key cannot complete it
    wr_reg(3'h1, 8'h55);
    wr_reg(3'h1, 8'h5a);
    wr_reg(3'h1, 8'haa);
    wr_reg(3'h0, 8'h16);
    idle();
    quiet("wrong key");
    wr_reg(3'h1, 8'h55);
    rd_chk(3'h1, 8'h00, "key mid sequence");
    wr_reg(3'h1, 8'haa);
    wr_reg(3'h0, 8'h16);
    idle();
    quiet("interrupted unlock");
    unlock(8'h12);
    quiet("enable clear");
    unlock(8'h56);
    quiet("config select");
    rd_chk(3'h0, 8'hd4, "start not set");
    $display("test refused sequences done");
    unlock(8'h16);
    for (int i = 0; i < 10 && erase !== 1'b1; i++) begin @(posedge clk); #1; end
    `CHK("erase pulse", 1'b1, erase)
    `CHK("erase row", 15'h0560, faddr)
    wait_idle();
    `CHK("no program on erase", 0, pulses)
    rd_chk(3'h0, 8'h84, "control after erase");
    $display("test erase done");
    // row 0x92: two latch loads, last word starts the write
    wr_reg(3'h3, 8'h12);
    wr_reg(3'h4, 8'h34);
    wr_reg(3'h5, 8'h12);
    wr_reg(3'h2, 8'h43);
    unlock(8'h26);
    exp_lat[3] = 14'h1234;
    wait_idle();
    rd_chk(3'h0, 8'ha4, "control after load");
    wr_reg(3'h2, 8'h45);
    wr_reg(3'h4, 8'hbc);
    wr_reg(3'h5, 8'h0a);
    unlock(8'h26);
    exp_lat[5] = 14'h0abc;
    wait_idle();
    `CHK("load only", 0, pulses)
    wr_reg(3'h2, 8'h5f);
    wr_reg(3'h4, 8'h01);
    wr_reg(3'h5, 8'h20);
    unlock(8'h06);
    exp_lat[31] = 14'h2001;
    row_burst(15'h1240);
    // a second write sees only blank latches except the one loaded
    wr_reg(3'h2, 8'h40);
    wr_reg(3'h4, 8'h11);
    wr_reg(3'h5, 8'h00);
    unlock(8'h06);
    exp_lat[0] = 14'h0011;
    row_burst(15'h1240);
    rd_chk(3'h0, 8'h84, "control after write");
    $display("test row write done");
    // reset in mid erase leaves the error flag set
    unlock(8'h16);
    repeat (6) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(3'h0, 8'h88, "error flag");
    wr_reg(3'h0, 8'h00);
    rd_chk(3'h0, 8'h80, "error cleared");
    $display("test reset error done");
    tally_and_finish();
  end
endmodule // flash_self_program_ctrl_tb
